//--- core/shc_pkg.sv
// Package for the sensor host command port controller: register map, codes, timing
package shc_pkg;
  // ==========================================================================
  // AHB-Lite register offsets of the controller (byte addresses)
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] RDATA_OFS  = 8'h0c;
  localparam logic [7:0] RXBYTE_OFS = 8'h10;
  // ==========================================================================
  // Command register fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_KIND_LSB = 16;
  localparam logic [1:0] KIND_READ  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_BURST = 2'h2;
  localparam logic [1:0] KIND_WORD  = 2'h3;
  // Control register fields
  localparam int CTRL_PORT_BIT = 0;
  localparam int CTRL_BAUD_LSB = 1;
  localparam int CTRL_LEN_LSB  = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ==========================================================================
  // Link protocol constants
  localparam logic [7:0] DELIM      = 8'h0d;
  localparam logic [7:0] BURST_ADDR = 8'h80;
  localparam logic [7:0] BURST_DATA = 8'h00;
  localparam int SPI_WORD_BITS = 16;
  // ==========================================================================
  // Timing, clock 40 MHz
  localparam int CLK_MHZ        = 40;
  localparam int SPI_HALF_NS    = 500;  // 1 MHz serial clock
  localparam int SPI_HALF_CYC   = SPI_HALF_NS * CLK_MHZ / 1000;
  localparam int SPI_STALL_US   = 20;
  localparam int SPI_STALL_CYC  = SPI_STALL_US * CLK_MHZ;
  localparam int SPI_RATE_US    = 40;
  localparam int SPI_RATE_CYC   = SPI_RATE_US * CLK_MHZ;
  localparam int SPI_BSTALL_US  = 45;
  localparam int SPI_BSTALL_CYC = SPI_BSTALL_US * CLK_MHZ;
  localparam int SPI_BRATE_US   = 8;
  localparam int SPI_BRATE_CYC  = SPI_BRATE_US * CLK_MHZ;
  // Serial bit times, rounded to whole cycles at 115.2/230.4/460.8 kbps
  localparam int BIT_CYC_115 = (CLK_MHZ * 1000000 + 115199) / 115200;
  localparam int BIT_CYC_230 = (CLK_MHZ * 1000000 + 230399) / 230400;
  localparam int BIT_CYC_460 = (CLK_MHZ * 1000000 + 460799) / 460800;
  // Command spacing in tenths of a microsecond
  localparam int RATE_115_DUS = 6600;
  localparam int RATE_230_DUS = 3500;
  localparam int RATE_460_DUS = 2000;
  localparam int PERB_115_DUS = 868;
  localparam int PERB_230_DUS = 434;
  localparam int PERB_460_DUS = 217;
endpackage : shc_pkg

//--- core/shc_host.sv
// Host controller driving the sensor's SPI or serial command port from AHB-Lite
// Notes on behaviour
// - Host uses only one port at a time; the idle port stays quiet.
// - SPI is 16-bit, data sampled on rising clock, clock idles high, select low.
// - SPI clock 0.01..2 MHz, 20 us between words, 40 us between commands.
// - SPI read answer comes out during the next 16-bit transfer.
// - SPI read word: bit15 zero, even address in 14:8, low byte ignored.
// - SPI write word: bit15 one, address in 14:8, data in low byte.
// - SPI burst: 45 us before first word, 8 us before next command; host waits the 20 us word gap.
// - Serial: 1 start, 8 data, 1 stop, no parity, 115.2/230.4/460.8 kbps.
// - Every serial command and answer ends with 0x0D.
// - Serial read: addr, dummy, 0x0D; answer addr, high, low, 0x0D.
// - Serial burst request is 0x80, 0x00, 0x0D.
// - Serial write: 1 plus address, data, 0x0D; no reply.
// - Serial commands spaced 660/350/200 us per rate.
// - After serial burst wait base plus 86.8/43.4/21.7 us per data byte.
// - Streaming exists only on the serial port.
// - Host issues no reads while streaming is active; host does not track streaming and sends every read command written while it is not busy.
`timescale 1ns/1ps
module shc_host #(
  parameter int BURST_BYTES = 18
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             uart_txd,
  input  wire logic        uart_rxd
);
  // Elaboration check: the length must fit the eight-bit count field
  if (BURST_BYTES < 1 || BURST_BYTES > 255) begin : g_bad_len
    $error("BURST_BYTES out of range");
  end

  typedef enum logic [2:0] {
    SHC_IDLE  = 3'b000,
    SHC_SHIFT = 3'b001,
    SHC_GAP   = 3'b010,
    SHC_UTX   = 3'b011,
    SHC_WAIT  = 3'b100
  } shc_state_t;

  // ==========================================================================
  // Bus slave: every access completes in its data phase with no wait state
  logic        wr_pend_r;
  logic [7:0]  wa_r;
  logic [31:0] ctrl_r;
  logic [31:0] rdata_r;
  logic [7:0]  rxbyte_r;
  logic        rxnew_r;
  logic        busy_r;
  shc_state_t  st_r;
  wire         a_ok    = hsel & htrans[1] & hready;
  wire         cmd_wr  = wr_pend_r & (wa_r == shc_pkg::CMD_OFS) & ~busy_r;
  wire         rx_rd   = a_ok & ~hwrite & (haddr[7:0] == shc_pkg::RXBYTE_OFS);
  wire         port_u  = ctrl_r[shc_pkg::CTRL_PORT_BIT];  // One port only
  wire  [1:0]  baud    = ctrl_r[shc_pkg::CTRL_BAUD_LSB +: 2];
  wire  [1:0]  kind    = hwdata[shc_pkg::CMD_KIND_LSB +: 2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
      ctrl_r    <= shc_pkg::CTRL_RST;
    end else begin
      wr_pend_r <= a_ok & hwrite;
      wa_r      <= haddr[7:0];
      if (wr_pend_r && wa_r == shc_pkg::CTRL_OFS && !busy_r) ctrl_r <= hwdata;
    end
  end

  // Read mux registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (a_ok && !hwrite) begin
      unique case (haddr[7:0])
        shc_pkg::CTRL_OFS:   hrdata <= ctrl_r;
        shc_pkg::STAT_OFS:   hrdata <= {29'h0, rxnew_r, port_u, busy_r};
        shc_pkg::RDATA_OFS:  hrdata <= rdata_r;
        shc_pkg::RXBYTE_OFS: hrdata <= {24'h0, rxbyte_r};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] miso_s_r;
  logic [1:0] rxd_s_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_s_r <= 2'b00;
      rxd_s_r  <= 2'b11;
    end else begin
      miso_s_r <= {miso_s_r[0], spi_miso};
      rxd_s_r  <= {rxd_s_r[0], uart_rxd};
    end
  end
  wire miso = miso_s_r[1];
  wire rxd  = rxd_s_r[1];

  // ==========================================================================
  // Bit time and command spacing chosen by the baud field
  wire [15:0] bit_cyc = (baud == 2'd1) ? 16'(shc_pkg::BIT_CYC_230) :
                        (baud == 2'd2) ? 16'(shc_pkg::BIT_CYC_460) :
                                         16'(shc_pkg::BIT_CYC_115);
  wire [31:0] base_dus = (baud == 2'd1) ? 32'(shc_pkg::RATE_230_DUS) :
                         (baud == 2'd2) ? 32'(shc_pkg::RATE_460_DUS) :
                                          32'(shc_pkg::RATE_115_DUS);
  wire [31:0] perb_dus = (baud == 2'd1) ? 32'(shc_pkg::PERB_230_DUS) :
                         (baud == 2'd2) ? 32'(shc_pkg::PERB_460_DUS) :
                                          32'(shc_pkg::PERB_115_DUS);
  wire [7:0]  blen     = ctrl_r[shc_pkg::CTRL_LEN_LSB +: 8];
  wire [31:0] u_gap    = (base_dus + perb_dus * 32'(blen)) * 32'(shc_pkg::CLK_MHZ) / 32'd10;

  // ==========================================================================
  // Transmit engine: SPI word or three serial bytes, then spacing
  logic [15:0] sh_r;
  logic [15:0] rx16_r;
  logic [23:0] ubytes_r;
  logic [31:0] cnt_r;
  logic [4:0]  bit_r;
  logic [1:0]  byte_r;
  logic [9:0]  uframe_r;
  logic [31:0] gap_r;
  wire         cnt_end = (cnt_r == 32'd0);
  wire  [7:0]  a_even  = {1'b0, hwdata[shc_pkg::CMD_ADDR_LSB +: 7] & 7'h7e};
  wire  [7:0]  a_any   = {1'b1, hwdata[shc_pkg::CMD_ADDR_LSB +: 7]};
  wire  [7:0]  d_byte  = hwdata[shc_pkg::CMD_DATA_LSB +: 8];
  // SPI words for each command kind
  wire  [15:0] spi_word = (kind == shc_pkg::KIND_READ)  ? {a_even, 8'h00} :
                          (kind == shc_pkg::KIND_WRITE) ? {a_any, d_byte} :
                          (kind == shc_pkg::KIND_BURST) ? {shc_pkg::BURST_ADDR, 8'h00} :
                                                          hwdata[15:0];
  // Serial commands, each closed by the delimiter
  wire  [23:0] u_cmd = (kind == shc_pkg::KIND_READ) ?
                         {a_even, 8'h00, shc_pkg::DELIM} :
                       (kind == shc_pkg::KIND_BURST) ?
                         {shc_pkg::BURST_ADDR, shc_pkg::BURST_DATA, shc_pkg::DELIM} :
                         {a_any, d_byte, shc_pkg::DELIM};
  // Spacing after a command: bursts need the longer first stall
  wire  [31:0] spi_gap = (kind == shc_pkg::KIND_BURST) ? 32'(shc_pkg::SPI_BSTALL_CYC) :
                         (kind == shc_pkg::KIND_WORD)  ? 32'(shc_pkg::SPI_BRATE_CYC) :
                                                         32'(shc_pkg::SPI_RATE_CYC);
  wire  [31:0] ugap_k  = (kind == shc_pkg::KIND_BURST) ? u_gap : (base_dus *
                         32'(shc_pkg::CLK_MHZ) / 32'd10);

  // Command sequencer; a command written while busy is dropped, software polls busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= SHC_IDLE;
      busy_r   <= 1'b0;
      spi_sclk <= 1'b1;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
      uart_txd <= 1'b1;
      sh_r     <= 16'h0000;
      rx16_r   <= 16'h0000;
      ubytes_r <= 24'h000000;
      uframe_r <= 10'h3ff;
      cnt_r    <= 32'd0;
      gap_r    <= 32'd0;
      bit_r    <= 5'd0;
      byte_r   <= 2'd0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      unique case (st_r)
        SHC_IDLE: begin
          if (cmd_wr && !port_u) begin
            busy_r   <= 1'b1;
            sh_r     <= spi_word;
            gap_r    <= (spi_gap > 32'(shc_pkg::SPI_STALL_CYC)) ? spi_gap :
                        32'(shc_pkg::SPI_STALL_CYC);
            spi_cs_n <= 1'b0;
            spi_mosi <= spi_word[15];  // High bit first
            bit_r    <= 5'(shc_pkg::SPI_WORD_BITS);
            cnt_r    <= 32'(shc_pkg::SPI_HALF_CYC);
            st_r     <= SHC_SHIFT;
          end else if (cmd_wr && port_u) begin  // Reads go out only on order, never unasked
            busy_r   <= 1'b1;
            ubytes_r <= u_cmd;
            gap_r    <= ugap_k;
            byte_r   <= 2'd3;
            uframe_r <= {1'b1, u_cmd[23:16], 1'b0};  // Start, data, stop
            cnt_r    <= 32'(bit_cyc) - 32'd1;  // Count ends inclusive, so one less
            bit_r    <= 5'd10;
            st_r     <= SHC_UTX;
          end
        end
        SHC_SHIFT: begin
          // Clock falls mid-bit, device samples on the rising edge
          if (cnt_end) begin
            cnt_r <= 32'(shc_pkg::SPI_HALF_CYC);
            if (spi_sclk) begin
              if (bit_r == 5'd0) begin
                spi_cs_n <= 1'b1;
                rdata_r  <= {16'h0000, rx16_r};  // Answer of previous read
                cnt_r    <= gap_r;
                st_r     <= SHC_WAIT;
              end else spi_sclk <= 1'b0;
            end else begin
              spi_sclk <= 1'b1;
              rx16_r   <= {rx16_r[14:0], miso};
              sh_r     <= {sh_r[14:0], 1'b0};
              bit_r    <= bit_r - 5'd1;
            end
          end else begin
            cnt_r <= cnt_r - 32'd1;
            if (!spi_sclk && cnt_r == 32'd1) spi_mosi <= sh_r[15];
          end
        end
        SHC_UTX: begin
          uart_txd <= uframe_r[0];
          if (cnt_end) begin
            cnt_r    <= 32'(bit_cyc) - 32'd1;
            uframe_r <= {1'b1, uframe_r[9:1]};
            bit_r    <= bit_r - 5'd1;
            if (bit_r == 5'd1) begin
              byte_r   <= byte_r - 2'd1;
              ubytes_r <= {ubytes_r[15:0], 8'h00};
              bit_r    <= 5'd10;
              uframe_r <= {1'b1, ubytes_r[15:8], 1'b0};
              if (byte_r == 2'd1) begin
                cnt_r <= gap_r;
                st_r  <= SHC_WAIT;
              end
            end
          end else cnt_r <= cnt_r - 32'd1;
        end
        SHC_WAIT: begin
          uart_txd <= 1'b1;
          spi_sclk <= 1'b1;
          if (cnt_end) begin
            busy_r <= 1'b0;
            st_r   <= SHC_IDLE;
          end else cnt_r <= cnt_r - 32'd1;
        end
        default: st_r <= SHC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Serial receiver: always listening so streamed packets are never lost
  logic [15:0] rcnt_r;
  logic [3:0]  rbit_r;
  logic [7:0]  rsh_r;
  logic        ract_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ract_r   <= 1'b0;
      rcnt_r   <= 16'd0;
      rbit_r   <= 4'd0;
      rsh_r    <= 8'h00;
      rxbyte_r <= 8'h00;
      rxnew_r  <= 1'b0;
    end else begin
      if (!ract_r) begin
        if (!rxd) begin
          ract_r <= 1'b1;
          rcnt_r <= bit_cyc + (bit_cyc >> 1);  // Middle of the first data bit
          rbit_r <= 4'd8;
        end
      end else if (rcnt_r == 16'd0) begin
        rcnt_r <= bit_cyc - 16'd1;  // Whole bit time between samples
        if (rbit_r == 4'd0) begin
          ract_r   <= 1'b0;
          rxbyte_r <= rsh_r;
        end else begin
          rsh_r  <= {rxd, rsh_r[7:1]};
          rbit_r <= rbit_r - 4'd1;
        end
      end else rcnt_r <= rcnt_r - 16'd1;
      // New byte flag: a fresh byte wins over the clearing read
      if (ract_r && rcnt_r == 16'd0 && rbit_r == 4'd0) rxnew_r <= 1'b1;
      else if (rx_rd) rxnew_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // Low time of the serial clock; a counter keeps the rate check cheap to evaluate
  logic [15:0] sclk_lo_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sclk_lo_r <= 16'd0;
    else if (spi_sclk) sclk_lo_r <= 16'd0;
    else sclk_lo_r <= sclk_lo_r + 16'd1;
  end
  chk_spi_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
    spi_cs_n |-> spi_sclk) else $error("SPI clock not idle high");
  chk_ports_exclusive: assert property (@(posedge hclk) disable iff (!hresetn)
    !spi_cs_n |-> uart_txd) else $error("Both ports active");
  chk_spi_half_period: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(spi_sclk) |-> sclk_lo_r == 16'(shc_pkg::SPI_HALF_CYC + 1))
    else $error("SPI half period wrong");
  chk_uart_start_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == SHC_UTX && $fell(uart_txd)) |-> !uart_txd[*8])
    else $error("Short start bit");
  chk_spi_word_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(spi_cs_n) |-> spi_cs_n[*8]) else $error("Select gap too short");
  chk_rd_after_word: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(spi_cs_n) && st_r == SHC_WAIT) |-> rdata_r[15:0] == rx16_r)
    else $error("Read word not captured");
  chk_busy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == SHC_WAIT) |-> busy_r) else $error("Busy dropped early");
  chk_cmd_delim: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_wr && port_u && !busy_r) |=> ubytes_r[7:0] == shc_pkg::DELIM)
    else $error("Delimiter missing");
endmodule : shc_host

//--- sim/shc_dev_model.sv
// Behavioural sensor model: SPI slave and serial command port
`timescale 1ns/1ps
module shc_dev_model #(
  parameter int  BURST_N = 2,
  parameter real BIT_NS  = 2170.14
) (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  input  wire logic rx_in,
  output logic      tx_out
);
  // ==========================================================
  // Register bytes, low byte kept at the even address
  logic [7:0]  mem [0:127];
  logic [15:0] last_word;
  logic [15:0] resp = 16'h0000;
  logic [15:0] pk = 16'hb000;
  logic        in_burst = 1'b0;
  logic [7:0]  ub [0:1];
  int          un = 0;
  // Lines start quiet: serial idles high; known register contents keep answers defined
  initial begin
    miso = 1'b0;
    tx_out = 1'b1;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  end
  // ==========================================================
  // SPI word; both ports listen at all times, no strap picks one
  always @(negedge cs_n) begin : spi_word
    logic [15:0] sh;
    logic [15:0] tx;
    tx = resp;
    miso = tx[15];
    for (int i = 0; i < 16; i++) begin
      @(posedge sclk);
      sh = {sh[14:0], mosi};
      @(negedge sclk or posedge cs_n);
      tx = {tx[14:0], 1'b0};
      miso = tx[15];
    end
    wait (cs_n === 1'b1);
    miso = ~miso;  // Released line must not look like valid data
    last_word = sh;
    if (sh[15]) begin
      mem[sh[14:8]] = sh[7:0];
      in_burst = (sh[14:0] == 15'h0000);
      pk = 16'hb000;
      resp = pk;
    end else if (in_burst) begin
      pk = pk + 16'h0001;
      resp = pk;
    end else begin
      resp = {mem[{sh[14:9], 1'b1}], mem[{sh[14:9], 1'b0}]};
    end
  end
  // ==========================================================
  // Serial receiver; a command acts only once its delimiter arrives
  initial begin : ser_rx
    logic [7:0] b;
    forever begin
      @(negedge rx_in);
      #(BIT_NS * 1.5);
      for (int i = 0; i < 8; i++) begin
        b[i] = rx_in;
        #(BIT_NS);
      end
      if (un == 2) begin
        if (b == 8'h0d) ser_act();
        un = 0;
      end else begin
        ub[un] = b;
        un++;
      end
    end
  end
  // Decode a complete serial command; answer reads and bursts, not writes
  task automatic ser_act();
    logic [6:0] a;
    a = ub[0][6:0];
    if (ub[0] == 8'h80 && ub[1] == 8'h00) begin
      send(8'h80);
      for (int i = 0; i < BURST_N; i++) send(8'hc0 + 8'(i));
      send(8'h0d);
    end else if (ub[0][7]) begin
      mem[a] = ub[1];
    end else begin
      send(ub[0]);
      send(mem[{a[6:1], 1'b1}]);
      send(mem[{a[6:1], 1'b0}]);
      send(8'h0d);
    end
  endtask
  // One frame: start, eight bits low first, stop
  task automatic send(input logic [7:0] b);
    tx_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      tx_out = b[i];
      #(BIT_NS);
    end
    tx_out = 1'b1;
    #(BIT_NS);
  endtask
endmodule // shc_dev_model

//--- sim/shc_host_tb_top.sv
// Self-checking bench for the host command port controller
`timescale 1ns/1ps
module shc_host_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        uart_txd;
  logic        uart_rxd;
  logic [31:0] junk;
  logic [1:0]  kind = 2'h0;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  int          sclk_n = 0;
  realtime     t_rise = 0.0;
  realtime     need = 0.0;
  // 40 MHz clock
  always #12.5 hclk = ~hclk;
  shc_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .uart_txd(uart_txd), .uart_rxd(uart_rxd));
  shc_dev_model #(.BURST_N(2)) dev (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso), .rx_in(uart_txd), .tx_out(uart_rxd));
  // ==========================================================
  // Shared checks and bus cycles
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Single word transfer; address phase held until hready is seen
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int n = 0; n < 20000 && s[0] !== 1'b0; n++)
      ahb(1'b0, {24'h0, shc_pkg::STAT_OFS}, 32'h0, s);
    chk("busy clears", 32'h0, {31'h0, s[0]});
  endtask
  task automatic cmd(input logic [1:0] k, input logic [6:0] a, input logic [7:0] d, input bit w);
    kind = k;
    ahb(1'b1, {24'h0, shc_pkg::CMD_OFS}, {14'h0, k, 1'b0, a, d}, junk);
    if (w) wait_idle();
  endtask
  // Polls the receive flag; bytes come far slower than a poll
  task automatic collect(input logic [31:0] exp);
    logic [31:0] s;
    int k;
    k = 0;
    for (int n = 0; n < 30000 && k < 4; n++) begin
      ahb(1'b0, {24'h0, shc_pkg::STAT_OFS}, 32'h0, s);
      if (s[2] === 1'b1) begin
        ahb(1'b0, {24'h0, shc_pkg::RXBYTE_OFS}, 32'h0, s);
        chk("serial byte", {24'h0, exp[31-8*k -: 8]}, {24'h0, s[7:0]});
        k++;
      end
    end
    chk("serial byte count", 32'd4, 32'(k));
  endtask
  // ==========================================================
  // SPI frame monitor: pulse count and idle gap after each kind
  always @(posedge spi_sclk) if (spi_cs_n === 1'b0) sclk_n++;
  always @(posedge spi_cs_n) if (hresetn === 1'b1) begin
    chk("sclk pulses", 32'd16, 32'(sclk_n));
    sclk_n = 0;
    t_rise = $realtime;
    need = (kind == shc_pkg::KIND_BURST) ? 45000.0 : (kind == shc_pkg::KIND_WORD) ? 8000.0 : 40000.0;
  end
  always @(negedge spi_cs_n) if (t_rise > 0.0) chk("spi gap", 32'd1, 32'($realtime - t_rise >= need));
  // Hang guard, about twice the expected run
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("idle lines", 32'h7, {29'h0, spi_cs_n, spi_sclk, uart_txd});
    ahb(1'b0, {24'h0, shc_pkg::CTRL_OFS}, 32'h0, junk);
    chk("ctrl reset", shc_pkg::CTRL_RST, junk);
    ahb(1'b0, 32'h0000_0020, 32'h0, junk);
    chk("unmapped read", 32'h0, junk);
    chk("okay resp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_spi_write();
    cmd(shc_pkg::KIND_WRITE, 7'h11, 8'ha5, 1);
    cmd(shc_pkg::KIND_WRITE, 7'h10, 8'h3c, 1);
    chk("spi write word", 32'h903c, {16'h0, dev.last_word});
    chk("stored byte", 32'ha5, {24'h0, dev.mem[17]});
  endtask
  task automatic t_spi_read();
    cmd(shc_pkg::KIND_READ, 7'h10, 8'h00, 1);
    chk("read word", 32'h10, {24'h0, dev.last_word[15:8]});
    cmd(shc_pkg::KIND_WORD, 7'h00, 8'h00, 1);
    ahb(1'b0, {24'h0, shc_pkg::RDATA_OFS}, 32'h0, junk);
    chk("spi response", 32'ha53c, {16'h0, junk[15:0]});
  endtask
  task automatic t_spi_burst();
    cmd(shc_pkg::KIND_BURST, 7'h00, 8'h00, 1);
    chk("burst word", 32'h8000, {16'h0, dev.last_word});
    for (int i = 0; i < 2; i++) begin
      cmd(shc_pkg::KIND_WORD, 7'h00, 8'h00, 1);
      ahb(1'b0, {24'h0, shc_pkg::RDATA_OFS}, 32'h0, junk);
      chk("burst data", 32'hb000 + 32'(i), {16'h0, junk[15:0]});
    end
  endtask
  task automatic t_ser_write();
    realtime t0;
    ahb(1'b1, {24'h0, shc_pkg::CTRL_OFS}, 32'h0000_0025, junk);
    t0 = $realtime;
    cmd(shc_pkg::KIND_WRITE, 7'h21, 8'h77, 1);
    chk("serial write", 32'h77, {24'h0, dev.mem[33]});
    chk("serial spacing", 32'd1, 32'($realtime - t0 >= 200000.0));
  endtask
  task automatic t_ser_read();
    cmd(shc_pkg::KIND_READ, 7'h10, 8'h00, 0);
    collect(32'h10a53c0d);
    wait_idle();
  endtask
  task automatic t_ser_burst();
    realtime t0;
    t0 = $realtime;
    cmd(shc_pkg::KIND_BURST, 7'h00, 8'h00, 0);
    collect(32'h80c0c10d);
    wait_idle();
    chk("burst spacing", 32'd1, 32'($realtime - t0 >= 243400.0));
  endtask
  // Main sequence: reset for 10 cycles, then each scenario in turn
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_spi_write();
    t_spi_read();
    t_spi_burst();
    t_ser_write();
    t_ser_read();
    t_ser_burst();
    conclude();
  end
endmodule // shc_host_tb_top
